// ===== rtl/mhp_pkg.sv
// constants shared by the station address, hash filter and phy management ends
package mhp_pkg;

    // ----------------------------------------------------------------
    // register port geometry
    // ----------------------------------------------------------------
    localparam int         IDX_W  = 4;
    localparam int         DATA_W = 32;
    localparam int         HASH_W = 6;

    // ----------------------------------------------------------------
    // device register indices (byte address on the host bus is 4x)
    // ----------------------------------------------------------------
    localparam logic [3:0] IDX_ADDR_HIGH   = 4'h2;
    localparam logic [3:0] IDX_ADDR_LOW    = 4'h3;
    localparam logic [3:0] IDX_HASH_UPPER  = 4'h4;
    localparam logic [3:0] IDX_HASH_LOWER  = 4'h5;
    localparam logic [3:0] IDX_MGMT_ACCESS = 4'h6;
    localparam logic [3:0] IDX_MGMT_DATA   = 4'h7;
    localparam logic [3:0] IDX_FILTER_CTRL = 4'hA;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] RST_ADDR_LOW  = 32'h0FFF_FFFF;
    localparam logic [15:0] RST_ADDR_HIGH = 16'hFFFF;
    localparam logic [31:0] RST_HASH      = 32'h0000_0000;
    localparam logic [31:0] RST_ZERO      = 32'h0000_0000;

    // ----------------------------------------------------------------
    // field positions of the management access and filter control registers
    // ----------------------------------------------------------------
    localparam int         ACC_PHYAD_LSB  = 11;
    localparam int         ACC_REGIDX_LSB = 6;
    localparam int         ACC_WSEL_BIT   = 1;
    localparam int         ACC_PEND_BIT   = 0;
    localparam int         FILT_ALL_BIT   = 0;
    localparam logic [4:0] PHY_ADDR_FIXED = 5'h01;

    // ----------------------------------------------------------------
    // eeprom locations holding the station address, wire order
    // ----------------------------------------------------------------
    localparam logic [7:0] EE_LOC_BYTE0 = 8'h01;
    localparam logic [7:0] EE_LOC_BYTE1 = 8'h02;
    localparam logic [7:0] EE_LOC_BYTE2 = 8'h03;
    localparam logic [7:0] EE_LOC_BYTE3 = 8'h04;
    localparam logic [7:0] EE_LOC_BYTE4 = 8'h05;
    localparam logic [7:0] EE_LOC_BYTE5 = 8'h06;

    // ----------------------------------------------------------------
    // management frame timing and layout
    // ----------------------------------------------------------------
    localparam int         CLK_PERIOD_NS     = 4;
    localparam int         MDC_MIN_PERIOD_NS = 400;
    localparam int         MDC_HALF_INT      =
        (MDC_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
    localparam logic [5:0] MDC_HALF_LAST     = 6'(MDC_HALF_INT - 1);
    localparam logic [5:0] FRAME_LAST_BIT    = 6'h3F;
    localparam logic [5:0] TA_FIRST_BIT      = 6'h2E;
    localparam logic [5:0] RD_FIRST_BIT      = 6'h30;
    localparam logic [31:0] PREAMBLE         = 32'hFFFF_FFFF;
    localparam logic [1:0] FRAME_START       = 2'h1;
    localparam logic [1:0] OP_WRITE          = 2'h1;
    localparam logic [1:0] OP_READ           = 2'h2;
    localparam logic [1:0] TA_WRITE          = 2'h2;
    localparam logic [1:0] TA_READ           = 2'h3;

    // ----------------------------------------------------------------
    // host side avalon map
    // ----------------------------------------------------------------
    localparam logic [7:0] HOST_STATUS_ADDR = 8'h40;
    localparam int         HST_PEND_BIT     = 0;
    localparam int         HST_INIT_BIT     = 1;
    localparam int         HST_REFUSED_BIT  = 2;

endpackage : mhp_pkg

// ===== rtl/mhp_csr_if.sv
// register port joining the controller end and the device register bank
`timescale 1ns/1ps
interface mhp_csr_if;
    logic        req;
    logic        wr;
    logic [3:0]  idx;
    logic [31:0] wdata;
    logic        ack;
    logic [31:0] rdata;
    logic        pending;
    logic        init_done;

    modport dev  (input req, wr, idx, wdata, output ack, rdata, pending, init_done);
    modport host (output req, wr, idx, wdata, input ack, rdata, pending, init_done);
endinterface : mhp_csr_if

// ===== rtl/mhp_csr_dev.sv
// station address, group hash filter and phy management register bank
`timescale 1ns/1ps
module mhp_csr_dev
    import mhp_pkg::*;
(
    input  wire logic                         core_clk,
    input  wire logic                         nrst,
    mhp_csr_if.dev                            csr,
    input  wire logic                         ee_byte_valid,
    input  wire logic [7:0]                   ee_byte_loc,
    input  wire logic [7:0]                   ee_byte,
    input  wire logic                         ee_load_done,
    input  wire logic                         filt_req,
    input  wire logic [mhp_pkg::HASH_W-1:0]   filt_hash,
    output logic                              filt_ack,
    output logic                              filt_accept,
    output logic                              mdc,
    output logic                              mdio_out,
    output logic                              mdio_oe_n,
    input  wire logic                         mdio_in
);
    import mhp_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] addr_low;
        logic [15:0] addr_high;
        logic [31:0] hash_upper;
        logic [31:0] hash_lower;
        logic [4:0]  phy_addr;
        logic [4:0]  phy_reg_index;
        logic        phy_write_select;
        logic        phy_access_pending;
        logic [15:0] mgmt_data;
        logic        accept_all_group;
        logic        init_done;
        logic        ack;
        logic [31:0] rdata;
        logic        filt_ack;
        logic        filt_accept;
        logic        mdc;
        logic        mdio_out;
        logic        mdio_oe_n;
        logic [5:0]  div;
        logic [5:0]  bit_cnt;
        logic [63:0] frame;
        logic [15:0] rd_shift;
        logic [1:0]  sync;
    } mhp_dev_state_t;

    mhp_dev_state_t s;
    mhp_dev_state_t next_s;

    // hash table lookup: msb picks the register, low five bits the bit
    function automatic logic hash_select(input logic [31:0] upper, input logic [31:0] lower,
                                         input logic [5:0] idx);
        hash_select = idx[5] ? upper[idx[4:0]] : lower[idx[4:0]];
    endfunction : hash_select

    // register read mux, reserved bits zero
    function automatic logic [31:0] read_value(input mhp_dev_state_t st, input logic [3:0] idx);
        read_value = RST_ZERO;
        unique case (idx)
            IDX_ADDR_LOW:    read_value = st.addr_low;
            IDX_ADDR_HIGH:   read_value = {16'h0000, st.addr_high};
            IDX_HASH_UPPER:  read_value = st.hash_upper;
            IDX_HASH_LOWER:  read_value = st.hash_lower;
            IDX_MGMT_ACCESS: read_value = {16'h0000, st.phy_addr, st.phy_reg_index, 4'h0,
                                           st.phy_write_select, st.phy_access_pending};
            IDX_MGMT_DATA:   read_value = {16'h0000, st.mgmt_data};
            IDX_FILTER_CTRL: read_value = {31'h0000_0000, st.accept_all_group};
            default:         read_value = RST_ZERO;
        endcase
    endfunction : read_value

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_s          = s;
        next_s.sync     = {s.sync[0], mdio_in};
        next_s.ack      = csr.req & ~s.ack;
        // group frame filter, one answer for each cycle that filt_req is high
        next_s.filt_ack    = filt_req;
        next_s.filt_accept = filt_req &
            (s.accept_all_group | hash_select(s.hash_upper, s.hash_lower, filt_hash));

        // register port access, one per request
        if (csr.req && !s.ack)
        begin
            next_s.rdata = csr.wr ? RST_ZERO : read_value(s, csr.idx);
            if (csr.wr)
            begin
                unique case (csr.idx)
                    IDX_ADDR_LOW:    next_s.addr_low   = csr.wdata;
                    IDX_ADDR_HIGH:   next_s.addr_high  = csr.wdata[15:0];
                    IDX_HASH_UPPER:  next_s.hash_upper = csr.wdata;
                    IDX_HASH_LOWER:  next_s.hash_lower = csr.wdata;
                    IDX_FILTER_CTRL: next_s.accept_all_group = csr.wdata[FILT_ALL_BIT];
                    IDX_MGMT_DATA:
                    begin
                        if (!s.phy_access_pending)
                            next_s.mgmt_data = csr.wdata[15:0];
                    end
                    IDX_MGMT_ACCESS:
                    begin
                        if (!s.phy_access_pending)
                        begin
                            next_s.phy_addr         = csr.wdata[ACC_PHYAD_LSB +: 5];
                            next_s.phy_reg_index    = csr.wdata[ACC_REGIDX_LSB +: 5];
                            next_s.phy_write_select = csr.wdata[ACC_WSEL_BIT];
                            if (csr.wdata[ACC_PEND_BIT])
                            begin
                                // launch one management frame
                                next_s.phy_access_pending = 1'b1;
                                next_s.frame = {PREAMBLE, FRAME_START,
                                    csr.wdata[ACC_WSEL_BIT] ? OP_WRITE : OP_READ,
                                    csr.wdata[ACC_PHYAD_LSB +: 5],
                                    csr.wdata[ACC_REGIDX_LSB +: 5],
                                    csr.wdata[ACC_WSEL_BIT] ? TA_WRITE : TA_READ,
                                    csr.wdata[ACC_WSEL_BIT] ? s.mgmt_data : 16'hFFFF};
                                next_s.bit_cnt   = 6'h00;
                                next_s.div       = 6'h00;
                                next_s.mdc       = 1'b0;
                                next_s.mdio_out  = PREAMBLE[31];
                                next_s.mdio_oe_n = 1'b0;
                            end
                        end
                    end
                    default: ;
                endcase
            end
        end

        // eeprom bytes land in wire order
        if (ee_byte_valid)
        begin
            unique case (ee_byte_loc)
                EE_LOC_BYTE0: next_s.addr_low[7:0]   = ee_byte;
                EE_LOC_BYTE1: next_s.addr_low[15:8]  = ee_byte;
                EE_LOC_BYTE2: next_s.addr_low[23:16] = ee_byte;
                EE_LOC_BYTE3: next_s.addr_low[31:24] = ee_byte;
                EE_LOC_BYTE4: next_s.addr_high[7:0]  = ee_byte;
                EE_LOC_BYTE5: next_s.addr_high[15:8] = ee_byte;
                default: ;
            endcase
        end
        if (ee_load_done)
            next_s.init_done = 1'b1;

        // management frame engine: shift on mdc fall, sample on rise
        if (s.phy_access_pending)
        begin
            if (s.div == MDC_HALF_LAST)
            begin
                next_s.div = 6'h00;
                next_s.mdc = ~s.mdc;
                if (!s.mdc)
                begin
                    if (!s.phy_write_select && s.bit_cnt >= RD_FIRST_BIT)
                        next_s.rd_shift = {s.rd_shift[14:0], s.sync[1]};
                end
                else if (s.bit_cnt == FRAME_LAST_BIT)
                begin
                    next_s.phy_access_pending = 1'b0;
                    next_s.mdio_oe_n          = 1'b1;
                    next_s.mdio_out           = 1'b1;
                    if (!s.phy_write_select)
                        next_s.mgmt_data = s.rd_shift;
                end
                else
                begin
                    next_s.bit_cnt  = s.bit_cnt + 6'h01;
                    next_s.frame    = {s.frame[62:0], 1'b1};
                    next_s.mdio_out = s.frame[62];
                    if (!s.phy_write_select && (s.bit_cnt + 6'h01) == TA_FIRST_BIT)
                        next_s.mdio_oe_n = 1'b1;
                end
            end
            else
                next_s.div = s.div + 6'h01;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s            <= '0;
            s.addr_low   <= RST_ADDR_LOW;
            s.addr_high  <= RST_ADDR_HIGH;
            s.hash_upper <= RST_HASH;
            s.hash_lower <= RST_HASH;
            s.mdio_out   <= 1'b1;
            s.mdio_oe_n  <= 1'b1;
            s.sync       <= 2'h3;
            s.rd_shift   <= 16'h0000;
        end
        else
            s <= next_s;
    end

    // outputs straight from flops
    assign csr.ack       = s.ack;
    assign csr.rdata     = s.rdata;
    assign csr.pending   = s.phy_access_pending;
    assign csr.init_done = s.init_done;
    assign filt_ack      = s.filt_ack;
    assign filt_accept   = s.filt_accept;
    assign mdc           = s.mdc;
    assign mdio_out      = s.mdio_out;
    assign mdio_oe_n     = s.mdio_oe_n;

endmodule : mhp_csr_dev

// ===== rtl/mhp_csr_host.sv
// controller end: avalon slave for software, drives the device register port
`timescale 1ns/1ps
module mhp_csr_host
    import mhp_pkg::*;
(
    input  wire logic                         core_clk,
    input  wire logic                         nrst,
    mhp_csr_if.host                           csr,
    input  wire logic [7:0]                   avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [mhp_pkg::DATA_W-1:0]   avs_writedata,
    output logic      [mhp_pkg::DATA_W-1:0]   avs_readdata,
    output logic                              avs_waitrequest
);
    import mhp_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {HS_IDLE, HS_FWD, HS_DONE} mhp_hstate_t;

    typedef struct packed {
        mhp_hstate_t state;
        logic        waitrequest;
        logic [31:0] readdata;
        logic        req;
        logic        wr;
        logic [3:0]  idx;
        logic [31:0] wdata;
        logic        refused;
    } mhp_host_state_t;

    mhp_host_state_t s;
    mhp_host_state_t next_s;

    // writes that the device must not see yet
    function automatic logic refuse_write(input logic [3:0] idx, input logic pend,
                                          input logic init);
        refuse_write = ((idx == IDX_MGMT_ACCESS || idx == IDX_MGMT_DATA) && pend)
                     || ((idx == IDX_ADDR_LOW || idx == IDX_ADDR_HIGH) && !init);
    endfunction : refuse_write

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        unique case (s.state)
            HS_IDLE:
            begin
                if (avs_read || avs_write)
                begin
                    next_s.state       = HS_DONE;
                    next_s.waitrequest = 1'b0;
                    next_s.readdata    = RST_ZERO;
                    if (avs_address == HOST_STATUS_ADDR)
                    begin
                        next_s.readdata[HST_PEND_BIT]    = csr.pending;
                        next_s.readdata[HST_INIT_BIT]    = csr.init_done;
                        next_s.readdata[HST_REFUSED_BIT] = s.refused;
                        if (avs_write && avs_writedata[HST_REFUSED_BIT])
                            next_s.refused = 1'b0;
                    end
                    else if (avs_address[7:6] != 2'h0 || avs_address[1:0] != 2'h0)
                        next_s.readdata = RST_ZERO;
                    else if (avs_write
                             && refuse_write(avs_address[5:2], csr.pending, csr.init_done))
                        next_s.refused = 1'b1;
                    else
                    begin
                        // forward to the device register port
                        next_s.state       = HS_FWD;
                        next_s.waitrequest = 1'b1;
                        next_s.req         = 1'b1;
                        next_s.wr          = avs_write;
                        next_s.idx         = avs_address[5:2];
                        next_s.wdata       = avs_writedata;
                        if (avs_address[5:2] == IDX_MGMT_ACCESS)
                            next_s.wdata[ACC_PHYAD_LSB +: 5] = PHY_ADDR_FIXED;
                    end
                end
            end
            HS_FWD:
            begin
                if (csr.ack)
                begin
                    next_s.req         = 1'b0;
                    next_s.readdata    = s.wr ? RST_ZERO : csr.rdata;
                    next_s.waitrequest = 1'b0;
                    next_s.state       = HS_DONE;
                end
            end
            HS_DONE:
            begin
                next_s.waitrequest = 1'b1;
                next_s.state       = HS_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s             <= '0;
            s.state       <= HS_IDLE;
            s.waitrequest <= 1'b1;
        end
        else
            s <= next_s;
    end

    // outputs straight from flops
    assign avs_readdata    = s.readdata;
    assign avs_waitrequest = s.waitrequest;
    assign csr.req         = s.req;
    assign csr.wr          = s.wr;
    assign csr.idx         = s.idx;
    assign csr.wdata       = s.wdata;

endmodule : mhp_csr_host

// ===== bench/mhp_csr_sva.sv
// assertions on the register port between the controller end and the device bank
`timescale 1ns/1ps
module mhp_csr_sva
    import mhp_pkg::*;
(
    input logic        core_clk,
    input logic        nrst,
    input logic        req,
    input logic        wr,
    input logic [3:0]  idx,
    input logic [31:0] wdata,
    input logic        ack,
    input logic [31:0] rdata,
    input logic        pending,
    input logic        init_done
);
    // ----------------
    // helper logic
    // ----------------
    logic [15:0] pend_cycles;
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // length of the running management access
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            pend_cycles <= 16'h0000;
        else
            pend_cycles <= pending ? pend_cycles + 16'h0001 : 16'h0000;
    end
    // ----------------
    // assertions
    // ----------------
    ack_after_req_a: assert property (req && !ack |=> ack)
        else $error("request not answered in the next cycle");
    ack_single_a: assert property (ack |=> !ack)
        else $error("answer longer than one cycle");
    req_steady_a: assert property (req && !ack
        |=> req && $stable(idx) && $stable(wr) && $stable(wdata))
        else $error("request changed before its answer");
    req_release_a: assert property (ack |=> !req)
        else $error("request kept after its answer");
    write_no_data_a: assert property (ack && wr |-> rdata == 32'h0000_0000)
        else $error("read data nonzero on a write answer");
    acc_reserved_a: assert property (ack && !wr && idx == IDX_MGMT_ACCESS
        |-> rdata[31:16] == 16'h0000 && rdata[5:2] == 4'h0)
        else $error("reserved access bits read nonzero");
    data_reserved_a: assert property (ack && !wr && idx == IDX_MGMT_DATA
        |-> rdata[31:16] == 16'h0000)
        else $error("reserved data bits read nonzero");
    high_reserved_a: assert property (ack && !wr && idx == IDX_ADDR_HIGH
        |-> rdata[31:16] == 16'h0000)
        else $error("reserved high address bits read nonzero");
    launch_pending_a: assert property (req && !ack && wr && idx == IDX_MGMT_ACCESS
        && wdata[0] && !pending |-> ##[1:3] pending)
        else $error("launch did not raise pending");
    pend_length_a: assert property ($fell(pending)
        |-> pend_cycles >= 16'h18FB && pend_cycles <= 16'h1905)
        else $error("management access length wrong");
    init_sticky_a: assert property (init_done |=> init_done)
        else $error("init done dropped");
    cover property ($fell(pending));
    cover property (ack && wr && idx == IDX_MGMT_ACCESS);
    cover property ($rose(init_done));
endmodule : mhp_csr_sva

// ===== bench/mac_addr_hash_phy_mgmt_csr_test.sv
// self-checking bench joining the controller end and the device bank
`timescale 1ns/1ps
module mac_addr_hash_phy_mgmt_csr_test;
    import mhp_pkg::*;
    logic        core_clk = 1'b0, nrst = 1'b0, ee_byte_valid = 1'b0, ee_load_done = 1'b0;
    logic        filt_req = 1'b0, avs_read = 1'b0, avs_write = 1'b0, resp = 1'b0, mdc_q = 1'b0;
    logic        filt_ack, filt_accept, mdc, mdio_out, mdio_oe_n, mdio_in, avs_waitrequest;
    logic [7:0]  ee_byte_loc = 8'h00, ee_byte = 8'h00, avs_address = 8'h00;
    logic [5:0]  filt_hash = 6'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, seed = 32'h0000_0061;
    logic [63:0] sh = 64'h0, tbl;
    logic [47:0] mac;
    logic [15:0] rd_val = 16'h0000, wd;
    logic [4:0]  ri;
    logic [31:0] q [$];
    logic [7:0]  ra [7] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h44};
    logic [31:0] rv [7] = '{0: 32'h0000_FFFF, 1: 32'h0FFF_FFFF, default: 32'h0000_0000};
    int          mismatches = 0, n_compared = 0, nf = 0;

    // ----------------
    // design and checker
    // ----------------
    mhp_csr_if ci();
    mhp_csr_dev mhp_csr_dev_i(.core_clk, .nrst, .csr(ci), .ee_byte_valid, .ee_byte_loc, .ee_byte,
        .ee_load_done, .filt_req, .filt_hash, .filt_ack, .filt_accept, .mdc, .mdio_out,
        .mdio_oe_n, .mdio_in);
    mhp_csr_host mhp_csr_host_i(.core_clk, .nrst, .csr(ci), .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
    mhp_csr_sva mhp_csr_sva_i(.core_clk, .nrst, .req(ci.req), .wr(ci.wr), .idx(ci.idx),
        .wdata(ci.wdata), .ack(ci.ack), .rdata(ci.rdata), .pending(ci.pending),
        .init_done(ci.init_done));

    // clock and shared data line
    always #2 core_clk = ~core_clk;
    assign mdio_in = mdio_oe_n ? resp : mdio_out;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        avs_address   <= a;
        avs_read      <= !w;
        avs_write     <= w;
        avs_writedata <= d;
        do @(posedge core_clk); while (avs_waitrequest);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(a, 1'b0, 32'h0000_0000);
    endtask : rd

    task filt(input logic [5:0] h, input logic e);
        filt_req  <= 1'b1;
        filt_hash <= h;
        q.push_back({31'h0, e});
        @(posedge core_clk);
        filt_req <= 1'b0;
        @(posedge core_clk);
    endtask : filt

    task final_report;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    // frame capture, phy answer and result monitor
    always @(posedge core_clk)
    begin
        mdc_q <= mdc;
        if (mdc && !mdc_q) sh <= {sh[62:0], mdio_out};
        nf <= !ci.pending ? 0 : nf + int'(!mdc && mdc_q);
        resp <= (nf >= 48 && nf <= 63) ? rd_val[63 - nf] : !resp;
        if (avs_read && !avs_waitrequest) check(avs_readdata, q.pop_front());
        if (filt_ack) check({31'h0, filt_accept}, q.pop_front());
    end

    // watchdog
    initial
    begin
        repeat (30000) @(posedge core_clk);
        mismatches++;
        final_report();
    end

    // ----------------
    // test sequence
    // ----------------
    initial
    begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        foreach (ra[i]) rd(ra[i], rv[i]);
        bus(8'h0C, 1'b1, 32'h1234_5678);
        rd(8'h0C, 32'h0FFF_FFFF);
        rd(8'h40, 32'h0000_0004);
        bus(8'h40, 1'b1, 32'h0000_0004);
        $display("test reset and early write finished");
        mac = {16'(xs()), xs()};
        for (int k = 1; k <= 6; k++)
        begin
            ee_byte_valid <= 1'b1;
            ee_byte_loc   <= 8'(k);
            ee_byte       <= mac[8*k-8 +: 8];
            @(posedge core_clk);
        end
        ee_byte_valid <= 1'b0;
        ee_load_done  <= 1'b1;
        @(posedge core_clk);
        ee_load_done <= 1'b0;
        @(posedge core_clk);
        rd(8'h0C, mac[31:0]);
        rd(8'h08, {16'h0000, mac[47:32]});
        rd(8'h40, 32'h0000_0002);
        bus(8'h0C, 1'b1, ~mac[31:0]);
        rd(8'h0C, ~mac[31:0]);
        $display("test eeprom load finished");
        tbl = {xs(), xs()};
        bus(8'h10, 1'b1, tbl[63:32]);
        bus(8'h14, 1'b1, tbl[31:0]);
        rd(8'h10, tbl[63:32]);
        rd(8'h14, tbl[31:0]);
        for (int m = 0; m < 2; m++)
        begin
            bus(8'h28, 1'b1, 32'(m));
            for (int i = 0; i < 64; i++) filt(6'(i), tbl[i] | m[0]);
        end
        rd(8'h28, 32'h0000_0001);
        $display("test hash filter finished");
        wd = 16'(xs());
        ri = 5'(xs());
        bus(8'h1C, 1'b1, {16'hFFFF, wd});
        rd(8'h1C, {16'h0000, wd});
        bus(8'h18, 1'b1, {16'hFFFF, 5'h1E, ri, 4'hF, 2'b11});
        rd(8'h18, {16'h0000, 5'h01, ri, 4'h0, 2'b11});
        bus(8'h1C, 1'b1, 32'h0000_0000);
        rd(8'h40, 32'h0000_0007);
        wait (!ci.pending);
        @(posedge core_clk);
        check(sh[63:32], 32'hFFFF_FFFF);
        check(sh[31:0], {2'b01, 2'b01, 5'h01, ri, 2'b10, wd});
        rd(8'h1C, {16'h0000, wd});
        bus(8'h40, 1'b1, 32'h0000_0004);
        $display("test phy write finished");
        rd_val = 16'(xs());
        ri = 5'(xs());
        bus(8'h18, 1'b1, {16'h0000, 5'h01, ri, 4'h0, 2'b01});
        wait (!ci.pending);
        @(posedge core_clk);
        check({18'h0, sh[31:18]}, {18'h0, 2'b01, 2'b10, 5'h01, ri});
        rd(8'h1C, {16'h0000, rd_val});
        rd(8'h18, {16'h0000, 5'h01, ri, 6'h00});
        $display("test phy read finished");
        final_report();
    end
endmodule : mac_addr_hash_phy_mgmt_csr_test
